// File: rtl/nsxla_alu.sv
// Datapath slice: nibble exchange, literal xor, two subtractions.
// Assumes decode presents one op per cycle with its operands;
// the register file write port is taken by the caller.
`timescale 1ns/1ps
`include "nsxla_defines.svh"
// Functional notes
// - Exchange swaps low and high nibbles.
// - Target bit 0 to accumulator, 1 register.
// - Literal xor accumulator into accumulator.
// - Negative subtraction clears borrow-free flag.
// - Zero or positive subtraction sets flag.
// - Literal minus accumulator into accumulator.
module nsxla_alu import nsxla_pkg::*; #(
	parameter int W = `NSXLA_DATA_W
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Operation
	input wire nsxla_op_e i_op,
	input wire logic i_target_reg,
	input wire logic [W-1:0] i_literal,
	input wire logic [W-1:0] i_reg_rdata,
	// Register file write
	output logic o_reg_we,
	output logic [W-1:0] o_reg_wdata,
	// Accumulator and flags
	output logic [W-1:0] o_acc,
	output logic o_carry,
	output logic o_digit_carry,
	output logic o_zero
);
	logic [W-1:0] acc;
	logic carry;
	logic digit_carry;
	logic zero;
	logic [W-1:0] reg_wdata;
	logic reg_we;
	logic [W-1:0] next_result;
	logic [W-1:0] sub_minuend;
	logic [W-1:0] sub_diff;
	logic sub_nb;
	logic sub_dnb;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [W-1:0] nibble_swap(input logic [W-1:0] v);
		return {v[`NSXLA_LO_NIB], v[`NSXLA_HI_NIB]};
	endfunction : nibble_swap

	// Shared zero test for xor and subtract results
	function automatic logic is_nil(input logic [W-1:0] v);
		return v == '0;
	endfunction : is_nil

	// ****************************************
	// Minuend select
	// ****************************************
	// Register subtract shares the register operand with the exchange
	always_comb begin
		if (i_op == NSXLA_OP_LITERAL_MINUS_ACC) begin
			sub_minuend = i_literal;
		end else begin
			sub_minuend = i_reg_rdata;
		end
	end

	// ****************************************
	// Subtractor
	// ****************************************
	nsxla_sub #(.W(W)) u_sub (
		.i_minuend(sub_minuend),
		.i_subtrahend(acc),
		.o_diff(sub_diff),
		.o_no_borrow(sub_nb),
		.o_digit_no_borrow(sub_dnb)
	);

	// ****************************************
	// Result select
	// ****************************************
	always_comb begin
		case (i_op)
			NSXLA_OP_NIBBLE_EXCHANGE: begin
				next_result = nibble_swap(i_reg_rdata);
			end
			NSXLA_OP_LITERAL_XOR: begin
				next_result = acc ^ i_literal;
			end
			NSXLA_OP_LITERAL_MINUS_ACC,
			NSXLA_OP_REGISTER_MINUS_ACC: begin
				next_result = sub_diff;
			end
			default: begin
				next_result = acc;
			end
		endcase
	end

	// ****************************************
	// Accumulator
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			acc <= W'(`NSXLA_ACC_RST);
		end else begin
			case (i_op)
				NSXLA_OP_NIBBLE_EXCHANGE,
				NSXLA_OP_REGISTER_MINUS_ACC: begin
					// Target bit only steers ops that read a register
					if (!i_target_reg) begin
						acc <= next_result;
					end
				end
				NSXLA_OP_LITERAL_XOR,
				NSXLA_OP_LITERAL_MINUS_ACC: begin
					acc <= next_result;
				end
				default: begin
					acc <= acc;
				end
			endcase
		end
	end

	// ****************************************
	// Register file write strobe
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			reg_we <= 1'b0;
		end else begin
			reg_we <= i_target_reg &&
				(i_op == NSXLA_OP_NIBBLE_EXCHANGE ||
				i_op == NSXLA_OP_REGISTER_MINUS_ACC);
		end
	end

	// ****************************************
	// Register file write data
	// ****************************************
	// Loaded every cycle; only meaningful with the strobe
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			reg_wdata <= '0;
		end else begin
			reg_wdata <= next_result;
		end
	end

	// ****************************************
	// Borrow-free flag
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			carry <= `NSXLA_FLAG_RST;
		end else begin
			case (i_op)
				NSXLA_OP_LITERAL_MINUS_ACC,
				NSXLA_OP_REGISTER_MINUS_ACC: begin
					carry <= sub_nb;
				end
				default: begin
					carry <= carry;
				end
			endcase
		end
	end

	// ****************************************
	// Low digit borrow-free flag
	// ****************************************
	// Kept for decimal adjust code; subtractions only
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			digit_carry <= `NSXLA_FLAG_RST;
		end else begin
			case (i_op)
				NSXLA_OP_LITERAL_MINUS_ACC,
				NSXLA_OP_REGISTER_MINUS_ACC: begin
					digit_carry <= sub_dnb;
				end
				default: begin
					digit_carry <= digit_carry;
				end
			endcase
		end
	end

	// ****************************************
	// Zero flag
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			zero <= `NSXLA_FLAG_RST;
		end else begin
			case (i_op)
				NSXLA_OP_LITERAL_MINUS_ACC,
				NSXLA_OP_REGISTER_MINUS_ACC: begin
					zero <= is_nil(sub_diff);
				end
				NSXLA_OP_LITERAL_XOR: begin
					zero <= is_nil(next_result);
				end
				default: begin
					zero <= zero;
				end
			endcase
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign o_acc = acc;
	assign o_carry = carry;
	assign o_digit_carry = digit_carry;
	assign o_zero = zero;
	assign o_reg_we = reg_we;
	assign o_reg_wdata = reg_wdata;
endmodule : nsxla_alu

// File: rtl/nsxla_defines.svh
// Constants for the nibble/xor/subtract datapath slice.
// Assumes inclusion by bare name from design files.
`ifndef NSXLA_DEFINES_SVH
`define NSXLA_DEFINES_SVH
`define NSXLA_DATA_W 8
`define NSXLA_ACC_RST 8'h00
`define NSXLA_FLAG_RST 1'b0
`define NSXLA_LO_NIB 3:0
`define NSXLA_HI_NIB 7:4
`define NSXLA_DIGIT_W 4
`define NSXLA_OP_W 5
`endif

// File: rtl/nsxla_pkg.sv
// Types for the nibble/xor/subtract datapath slice.
// Assumes the defines header is compiled alongside.
package nsxla_pkg;
	typedef enum logic [4:0] {
		NSXLA_OP_NONE = 5'h01,
		NSXLA_OP_NIBBLE_EXCHANGE = 5'h02,
		NSXLA_OP_LITERAL_XOR = 5'h04,
		NSXLA_OP_LITERAL_MINUS_ACC = 5'h08,
		NSXLA_OP_REGISTER_MINUS_ACC = 5'h10
	} nsxla_op_e;
endpackage : nsxla_pkg

// File: rtl/nsxla_sub.sv
// Two's complement subtractor: minuend minus accumulator.
// Purely combinational; used by the datapath top.
`timescale 1ns/1ps
`include "nsxla_defines.svh"
module nsxla_sub #(
	parameter int W = `NSXLA_DATA_W
) (
	// Operands
	input wire logic [W-1:0] i_minuend,
	input wire logic [W-1:0] i_subtrahend,
	// Results
	output logic [W-1:0] o_diff,
	output logic o_no_borrow,
	output logic o_digit_no_borrow
);
	logic [W:0] wide;
	logic [4:0] low;
	always_comb begin
		// Add inverted subtrahend plus one; carry out is borrow-free
		wide = {1'b0, i_minuend} + {1'b0, ~i_subtrahend} + {{W{1'b0}}, 1'b1};
		low = {1'b0, i_minuend[3:0]} + {1'b0, ~i_subtrahend[3:0]} + 5'h01;
		o_diff = wide[W-1:0];
		o_no_borrow = wide[W];
		o_digit_no_borrow = low[4];
	end
endmodule : nsxla_sub

// File: verification/nsxla_alu_properties.sv
// Port checker for the datapath slice.
// Assumes binding to nsxla_alu at its default width.
`timescale 1ns/1ps
module nsxla_alu_properties import nsxla_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire nsxla_op_e i_op,
	input wire logic i_target_reg,
	input wire logic [7:0] i_literal,
	input wire logic [7:0] i_reg_rdata,
	input wire logic o_reg_we,
	input wire logic [7:0] o_reg_wdata,
	input wire logic [7:0] o_acc,
	input wire logic o_carry,
	input wire logic o_digit_carry,
	input wire logic o_zero
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Op taken last edge, zero while in reset
	logic [4:0] p;
	always_ff @(posedge i_mclk) p <= i_rst ? 5'h00 : i_op;
	a_swap_acc: assert property (p == 5'h02 && !$past(i_target_reg) |->
		o_acc == {$past(i_reg_rdata[3:0]), $past(i_reg_rdata[7:4])})
		else $error("exchange result wrong");
	a_swap_reg: assert property (p == 5'h02 && $past(i_target_reg) |->
		o_reg_we && o_reg_wdata == {$past(i_reg_rdata[3:0]),
		$past(i_reg_rdata[7:4])} && $stable(o_acc))
		else $error("exchange write wrong");
	a_xor_acc: assert property (p == 5'h04 |->
		o_acc == ($past(o_acc) ^ $past(i_literal)) && !o_reg_we)
		else $error("xor result wrong");
	a_lit_borrow: assert property (p == 5'h08 |->
		o_carry == ($past(i_literal) >= $past(o_acc)))
		else $error("literal subtract carry wrong");
	a_reg_borrow: assert property (p == 5'h10 |->
		o_carry == ($past(i_reg_rdata) >= $past(o_acc)))
		else $error("register subtract carry wrong");
	a_lit_diff: assert property (p == 5'h08 |->
		o_acc == 8'($past(i_literal) - $past(o_acc)))
		else $error("literal subtract result wrong");
	a_xor_flags: assert property (p == 5'h04 |->
		o_zero == (o_acc == 8'h00) && $stable(o_carry))
		else $error("xor flags wrong");
	a_swap_flags: assert property (p == 5'h02 |->
		$stable(o_carry) && $stable(o_digit_carry) && $stable(o_zero))
		else $error("exchange changed flags");
	a_lit_digit: assert property (p == 5'h08 |->
		o_digit_carry == ($past(i_literal[3:0]) >= $past(o_acc[3:0])))
		else $error("literal subtract digit carry wrong");
	a_reg_digit: assert property (p == 5'h10 |->
		o_digit_carry == ($past(i_reg_rdata[3:0]) >= $past(o_acc[3:0])))
		else $error("register subtract digit carry wrong");
endmodule : nsxla_alu_properties

// File: verification/nsxla_alu_bench.sv
// Self-checking bench for the datapath slice.
// Assumes the checker file is compiled first.
`timescale 1ns/1ps
module nsxla_alu_bench import nsxla_pkg::*; ;
	logic i_mclk = 1'b0, i_rst = 1'b1, i_target_reg = 1'b0;
	nsxla_op_e i_op = NSXLA_OP_NONE;
	logic [7:0] i_literal = 8'h00, i_reg_rdata = 8'h00;
	logic o_reg_we, o_digit_carry, o_carry, o_zero;
	logic [7:0] o_reg_wdata, o_acc;
	int errors = 0, n_compared = 0;
	// Op, target, literal, register, result, carry, zero, write
	logic [32:0] rows [11] = '{
		{5'h04, 1'h0, 8'hb5, 8'h00, 8'hb5, 3'h0},
		{5'h04, 1'h0, 8'haf, 8'h00, 8'h1a, 3'h0},
		{5'h04, 1'h1, 8'h1a, 8'h00, 8'h00, 3'h2},
		{5'h02, 1'h0, 8'h00, 8'ha5, 8'h5a, 3'h2},
		{5'h02, 1'h1, 8'h00, 8'h3c, 8'hc3, 3'h3},
		{5'h08, 1'h0, 8'h5a, 8'h00, 8'h00, 3'h6},
		{5'h08, 1'h0, 8'h02, 8'h00, 8'h02, 3'h4},
		{5'h10, 1'h0, 8'h00, 8'h01, 8'hff, 3'h0},
		{5'h10, 1'h1, 8'h00, 8'h03, 8'h04, 3'h1},
		{5'h10, 1'h1, 8'h00, 8'hff, 8'h00, 3'h7},
		{5'h01, 1'h0, 8'hff, 8'hff, 8'hff, 3'h6}};
	nsxla_alu u_dut (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_op(i_op),
		.i_target_reg(i_target_reg),
		.i_literal(i_literal),
		.i_reg_rdata(i_reg_rdata),
		.o_reg_we(o_reg_we),
		.o_reg_wdata(o_reg_wdata),
		.o_acc(o_acc),
		.o_carry(o_carry),
		.o_digit_carry(o_digit_carry),
		.o_zero(o_zero)
	);
	initial forever #5 i_mclk = ~i_mclk;
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	initial begin
		repeat (10) @(posedge i_mclk);
		#1 i_rst = 1'b0;
		chk("reset state", {o_acc, o_carry, o_digit_carry, o_zero, o_reg_we},
			12'h000);
		chk("reset wdata", o_reg_wdata, 8'h00);
		$display("reset test done");
		foreach (rows[k]) begin
			i_op = nsxla_op_e'(rows[k][32:28]);
			{i_target_reg, i_literal, i_reg_rdata} = rows[k][27:11];
			@(posedge i_mclk) #1;
			chk("result", rows[k][0] ? o_reg_wdata : o_acc, rows[k][10:3]);
			chk("flags", {o_carry, o_zero, o_reg_we}, rows[k][2:0]);
		end
		$display("row test done");
		i_rst = 1'b1;
		i_op = NSXLA_OP_LITERAL_XOR;
		@(posedge i_mclk) #1;
		chk("mid reset", {o_acc, o_carry, o_digit_carry, o_zero, o_reg_we},
			12'h000);
		$display("mid reset test done");
		i_rst = 1'b0;
		i_literal = 8'h01;
		@(posedge i_mclk) #1;
		chk("first op after reset", o_acc, 8'h01);
		i_op = NSXLA_OP_LITERAL_MINUS_ACC;
		i_literal = 8'h10;
		@(posedge i_mclk) #1;
		chk("literal digit", {o_acc, o_carry, o_digit_carry}, 10'h03e);
		i_op = NSXLA_OP_REGISTER_MINUS_ACC;
		i_target_reg = 1'b0;
		i_reg_rdata = 8'h1f;
		@(posedge i_mclk) #1;
		chk("register digit", {o_acc, o_carry, o_digit_carry}, 10'h043);
		i_op = NSXLA_OP_NONE;
		$display("digit carry test done");
		end_sim();
	end
endmodule : nsxla_alu_bench
bind nsxla_alu nsxla_alu_properties u_props (
	.i_mclk(i_mclk),
	.i_rst(i_rst),
	.i_op(i_op),
	.i_target_reg(i_target_reg),
	.i_literal(i_literal),
	.i_reg_rdata(i_reg_rdata),
	.o_reg_we(o_reg_we),
	.o_reg_wdata(o_reg_wdata),
	.o_acc(o_acc),
	.o_carry(o_carry),
	.o_digit_carry(o_digit_carry),
	.o_zero(o_zero)
);
